// [csf_pkg.sv]
// Shared constants, register map, field layouts and types for the capacitive sense frequency counter.
package csf_pkg;

  // Bus address width and data width.
  localparam int unsigned AXI_AW = 12;
  localparam int unsigned AXI_DW = 32;

  // Register byte offsets, one aligned word each.
  localparam logic [AXI_AW-1:0] OFF_SENSE_CTRL = 12'h000;
  localparam logic [AXI_AW-1:0] OFF_GATE_CTRL = 12'h004;
  localparam logic [AXI_AW-1:0] OFF_COUNTER_CTRL = 12'h008;
  localparam logic [AXI_AW-1:0] OFF_GATED_COUNT = 12'h00c;
  localparam logic [AXI_AW-1:0] OFF_BASIC_COUNT = 12'h010;

  // Sense control field positions.
  localparam int unsigned SC_ENABLE_BIT = 7;
  localparam int unsigned SC_RANGE_HI = 3;
  localparam int unsigned SC_RANGE_LO = 2;
  localparam int unsigned SC_STATUS_BIT = 1;
  localparam int unsigned SC_CLKSEL_BIT = 0;

  // Gate control field positions.
  localparam int unsigned GC_ENABLE_BIT = 7;
  localparam int unsigned GC_TOGGLE_BIT = 6;
  localparam int unsigned GC_OPEN_BIT = 3;
  localparam int unsigned GC_SRC_HI = 1;
  localparam int unsigned GC_SRC_LO = 0;

  // Gated counter control field position.
  localparam int unsigned CC_ON_BIT = 0;

  // Oscillator current range codes.
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam logic [1:0] RANGE_LOW = 2'h1;
  localparam logic [1:0] RANGE_MED = 2'h2;
  localparam logic [1:0] RANGE_HIGH = 2'h3;

  // Gate source code that selects the watchdog overflow.
  localparam logic [1:0] GATE_SRC_WDT = 2'h3;

  // Counter widths and the number of gate sources.
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BASIC_W = 8;
  localparam int unsigned NUM_GATE_SRC = 4;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sense control register contents that software writes.
  typedef struct packed {
    logic enable;
    logic [1:0] range;
    logic clk_sel;
  } csf_sense_ctrl_t;

  // Gate and gated counter configuration.
  typedef struct packed {
    logic gate_enable;
    logic toggle_mode;
    logic [1:0] source_select;
    logic counter_on;
  } csf_gate_cfg_t;

  // Reset values of the configuration registers.
  localparam csf_sense_ctrl_t SENSE_CTRL_RST = '{enable: 1'b0, range: 2'h0, clk_sel: 1'b0};
  localparam csf_gate_cfg_t GATE_CFG_RST = '{gate_enable: 1'b0, toggle_mode: 1'b0, source_select: 2'h0,
                                              counter_on: 1'b0};

  // Write channel states.
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } csf_wr_state_t;

  // Read channel states.
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } csf_rd_state_t;

  // Picks the new byte when its lane strobe is set, else keeps the old one.
  function automatic logic [7:0] csf_merge_byte(input logic [7:0] old_b, input logic [7:0] new_b,
                                                input logic en);
    csf_merge_byte = en ? new_b : old_b;
  endfunction

endpackage

// [csf_sync_edge.sv]
// Two-stage synchroniser with a rising-edge pulse for the sense oscillator.
`timescale 1ns/1ns
`default_nettype none
module csf_sync_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic level,
  output logic rise
);
  import csf_pkg::*;

  logic ff1_q, ff1_d; // First stage, read only by the second stage.
  logic ff2_q, ff2_d; // Second stage, the synchronised level.
  logic ff3_q, ff3_d; // Delayed copy for edge detection.

  // Next values of the synchroniser chain.
  always_comb begin
    ff1_d = async_in;
    ff2_d = ff1_q;
    ff3_d = ff2_q;
  end

  // Registers of the synchroniser chain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_q <= 1'b0;
      ff2_q <= 1'b0;
      ff3_q <= 1'b0;
    end else begin
      ff1_q <= ff1_d;
      ff2_q <= ff2_d;
      ff3_q <= ff3_d;
    end
  end

  // A rising edge is seen only after both stages, never on the raw input.
  assign level = ff2_q;
  assign rise = ff2_q & ~ff3_q;

  // One oscillator edge yields exactly one pulse.
  a_rise_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn) rise |=> !rise)
    else $error("oscillator edge pulse lasted more than one cycle");

endmodule
`default_nettype wire

// [csf_gate_counter.sv]
// Gate logic with toggle mode and the gated oscillator counter.
`timescale 1ns/1ns
`default_nettype none
module csf_gate_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire csf_pkg::csf_gate_cfg_t cfg,
  input wire logic [csf_pkg::NUM_GATE_SRC-1:0] gate_lvl,
  input wire logic osc_rise,
  input wire logic load_en,
  input wire logic [csf_pkg::CNT_W-1:0] load_val,
  output logic [csf_pkg::CNT_W-1:0] count,
  output logic window_open
);
  import csf_pkg::*;

  logic [NUM_GATE_SRC-1:0] lvl_prev_q, lvl_prev_d; // Previous gate levels for edge detection.
  logic window_q, window_d; // Toggle-mode gate state.
  logic [CNT_W-1:0] count_q, count_d; // Accumulated oscillator count.
  logic gate_pulse; // Single-cycle event on the selected source.
  logic gate_level; // Level of the selected source.
  logic count_en; // Counter may advance this cycle.
  logic inc; // Counter advances this cycle.

  // Selects the gate source and turns its rising edge into a one-cycle event.
  always_comb begin
    gate_level = gate_lvl[cfg.source_select];
    gate_pulse = gate_lvl[cfg.source_select] & ~lvl_prev_q[cfg.source_select];
    lvl_prev_d = gate_lvl;
  end

  // Toggle state: flips on each event and is cleared when the mode is left.
  always_comb begin
    if (!cfg.gate_enable || !cfg.toggle_mode) begin
      window_d = 1'b0;
    end else begin
      window_d = window_q ^ gate_pulse;
    end
  end

  // Counter enable and next count; a load coinciding with an edge keeps the edge.
  always_comb begin
    if (!cfg.counter_on) begin
      count_en = 1'b0;
    end else if (!cfg.gate_enable) begin
      count_en = 1'b1;
    end else begin
      count_en = cfg.toggle_mode ? window_q : gate_level;
    end
    // Every oscillator edge in an open window adds one, so a heavier pad gives fewer counts.
    inc = count_en & osc_rise;
    if (load_en) begin
      count_d = load_val + {{(CNT_W-1){1'b0}}, inc};
    end else if (inc) begin
      count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      count_d = count_q;
    end
  end

  // Registers of the gate and counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_prev_q <= '0;
      window_q <= 1'b0;
      count_q <= '0;
    end else begin
      lvl_prev_q <= lvl_prev_d;
      window_q <= window_d;
      count_q <= count_d;
    end
  end

  assign count = count_q;
  assign window_open = window_q;

  // A watchdog event in toggle mode opens a closed window.
  a_wdt_opens_window: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.gate_enable && cfg.toggle_mode && cfg.source_select == GATE_SRC_WDT && gate_pulse && !window_q
     && $stable(cfg)) |=> window_q)
    else $error("watchdog event did not open the gate window");

  // A second event closes it and the count then holds.
  a_second_closes: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.gate_enable && cfg.toggle_mode && gate_pulse && window_q) |=> (!window_q ##1 (load_en || $stable(count_q))))
    else $error("second gate event did not close the window");

  // Leaving toggle mode or disabling the gate clears the window.
  a_window_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.gate_enable || !cfg.toggle_mode) |=> !window_q)
    else $error("gate window not cleared outside toggle mode");

  // A counter that is off never moves without a load.
  a_off_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.counter_on && !load_en) |=> count_q == $past(count_q))
    else $error("gated counter moved while off");

endmodule
`default_nettype wire

// [csf_top.sv]
// Capacitive sense frequency counter with its AXI4-Lite register file.
`timescale 1ns/1ns
`default_nettype none
module csf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [csf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [csf_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [csf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [csf_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_sleep,
  input wire logic osc_in,
  input wire logic wdt_overflow,
  input wire logic [2:0] gate_alt_in,
  output logic sense_powered,
  output logic osc_run,
  output logic [1:0] osc_current_range
);
  import csf_pkg::*;

  // Returns the word-aligned form of a byte address.
  function automatic logic [AXI_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
    word_of = {a[AXI_AW-1:2], 2'b00};
  endfunction

  // Tells whether a byte address falls on a mapped register.
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = word_of(a);
    is_mapped = (w == OFF_SENSE_CTRL) || (w == OFF_GATE_CTRL) || (w == OFF_COUNTER_CTRL) ||
                (w == OFF_GATED_COUNT) || (w == OFF_BASIC_COUNT);
  endfunction

  // Write channel state.
  csf_wr_state_t wr_state_q, wr_state_d; // Write channel phase.
  logic aw_got_q, aw_got_d; // Write address already taken.
  logic w_got_q, w_got_d; // Write data already taken.
  logic [AXI_AW-1:0] waddr_q, waddr_d; // Held write address.
  logic [AXI_DW-1:0] wdata_q, wdata_d; // Held write data.
  logic [3:0] wstrb_q, wstrb_d; // Held write strobes.
  logic [1:0] bresp_q, bresp_d; // Write response code.

  // Read channel state.
  csf_rd_state_t rd_state_q, rd_state_d; // Read channel phase.
  logic [AXI_DW-1:0] rdata_q, rdata_d; // Read data being returned.
  logic [1:0] rresp_q, rresp_d; // Read response code.

  // Register file state.
  csf_sense_ctrl_t sense_q, sense_d; // Sense control fields.
  csf_gate_cfg_t gate_cfg_q, gate_cfg_d; // Gate and counter configuration.
  logic [BASIC_W-1:0] basic_q, basic_d; // Basic counter.

  // Combinational helpers.
  logic aw_fire; // Address handshake this cycle.
  logic w_fire; // Data handshake this cycle.
  logic do_write; // Both halves present, write commits.
  logic [AXI_AW-1:0] cur_addr; // Address of the committing write.
  logic [AXI_DW-1:0] cur_data; // Data of the committing write.
  logic [3:0] cur_strb; // Strobes of the committing write.
  logic load_en; // Gated counter load strobe.
  logic [CNT_W-1:0] load_val; // Gated counter load value.
  logic [CNT_W-1:0] gated_count; // Gated counter value.
  logic window_open; // Toggle-mode window state.
  logic osc_level; // Synchronised oscillator level.
  logic osc_rise; // Synchronised oscillator edge.
  logic osc_edge_live; // Oscillator edge from a running oscillator.
  logic basic_inc; // Basic counter advances.
  logic [NUM_GATE_SRC-1:0] gate_lvl; // Gate source levels.
  logic [7:0] sense_rd; // Sense control as read.
  logic [7:0] gate_rd; // Gate control as read.

  // Handshake readiness: each half is taken once and held until the pair commits.
  assign s_axi_awready = (wr_state_q == WR_IDLE) && !aw_got_q;
  assign s_axi_wready = (wr_state_q == WR_IDLE) && !w_got_q;
  assign s_axi_arready = (rd_state_q == RD_IDLE);
  assign s_axi_bvalid = (wr_state_q == WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = (rd_state_q == RD_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write channel: address and data arrive in any order; the response follows both.
  always_comb begin
    aw_fire = s_axi_awvalid && s_axi_awready;
    w_fire = s_axi_wvalid && s_axi_wready;
    cur_addr = aw_got_q ? waddr_q : s_axi_awaddr;
    cur_data = w_got_q ? wdata_q : s_axi_wdata;
    cur_strb = w_got_q ? wstrb_q : s_axi_wstrb;
    do_write = (wr_state_q == WR_IDLE) && (aw_got_q || aw_fire) && (w_got_q || w_fire);
    wr_state_d = wr_state_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    unique case (wr_state_q)
      WR_IDLE: begin
        if (do_write) begin
          // Commit and answer; an unmapped address is refused with a slave error.
          wr_state_d = WR_RESP;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          bresp_d = is_mapped(cur_addr) ? RESP_OKAY : RESP_SLVERR;
        end else begin
          // Keep whichever half has arrived alone.
          if (aw_fire) begin
            aw_got_d = 1'b1;
            waddr_d = s_axi_awaddr;
          end
          if (w_fire) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
          end
        end
      end
      WR_RESP: begin
        // Response stands until the master takes it.
        if (s_axi_bready) begin
          wr_state_d = WR_IDLE;
        end
      end
    endcase
  end

  // Write channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
    end
  end

  // Readback images; unimplemented bits read as zero and the status bit is live.
  always_comb begin
    sense_rd = 8'h00;
    sense_rd[SC_ENABLE_BIT] = sense_q.enable;
    sense_rd[SC_RANGE_HI:SC_RANGE_LO] = sense_q.range;
    sense_rd[SC_STATUS_BIT] = osc_run & osc_level;
    sense_rd[SC_CLKSEL_BIT] = sense_q.clk_sel;
    gate_rd = 8'h00;
    gate_rd[GC_ENABLE_BIT] = gate_cfg_q.gate_enable;
    gate_rd[GC_TOGGLE_BIT] = gate_cfg_q.toggle_mode;
    gate_rd[GC_OPEN_BIT] = window_open;
    gate_rd[GC_SRC_HI:GC_SRC_LO] = gate_cfg_q.source_select;
  end

  // Read channel: one read at a time, data registered on the address handshake.
  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rd_state_q)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_d = RD_DATA;
          rresp_d = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          rdata_d = '0;
          unique case (word_of(s_axi_araddr))
            OFF_SENSE_CTRL: rdata_d[7:0] = sense_rd;
            OFF_GATE_CTRL: rdata_d[7:0] = gate_rd;
            OFF_COUNTER_CTRL: rdata_d[CC_ON_BIT] = gate_cfg_q.counter_on;
            OFF_GATED_COUNT: rdata_d[CNT_W-1:0] = gated_count;
            OFF_BASIC_COUNT: rdata_d[BASIC_W-1:0] = basic_q;
            default: rdata_d = '0;
          endcase
        end
      end
      RD_DATA: begin
        // Data stands until the master takes it.
        if (s_axi_rready) begin
          rd_state_d = RD_IDLE;
        end
      end
    endcase
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= RD_IDLE;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Register file writes with byte-lane strobes; the basic counter stops in sleep.
  always_comb begin
    sense_d = sense_q;
    gate_cfg_d = gate_cfg_q;
    basic_inc = sense_q.clk_sel && !core_sleep && osc_edge_live;
    basic_d = basic_q + {{(BASIC_W-1){1'b0}}, basic_inc};
    load_en = 1'b0;
    load_val = gated_count;
    if (do_write && cur_strb[0]) begin
      unique case (word_of(cur_addr))
        OFF_SENSE_CTRL: begin
          sense_d.enable = cur_data[SC_ENABLE_BIT];
          sense_d.range = cur_data[SC_RANGE_HI:SC_RANGE_LO];
          sense_d.clk_sel = cur_data[SC_CLKSEL_BIT];
        end
        OFF_GATE_CTRL: begin
          gate_cfg_d.gate_enable = cur_data[GC_ENABLE_BIT];
          gate_cfg_d.toggle_mode = cur_data[GC_TOGGLE_BIT];
          gate_cfg_d.source_select = cur_data[GC_SRC_HI:GC_SRC_LO];
        end
        OFF_COUNTER_CTRL: gate_cfg_d.counter_on = cur_data[CC_ON_BIT];
        OFF_BASIC_COUNT: basic_d = cur_data[BASIC_W-1:0] + {{(BASIC_W-1){1'b0}}, basic_inc};
        default: begin
        end
      endcase
    end
    // The gated count is loaded per byte lane so either half can be cleared.
    if (do_write && (cur_strb[1:0] != 2'b00) && (word_of(cur_addr) == OFF_GATED_COUNT)) begin
      load_en = 1'b1;
      load_val = {csf_merge_byte(gated_count[15:8], cur_data[15:8], cur_strb[1]),
                  csf_merge_byte(gated_count[7:0], cur_data[7:0], cur_strb[0])};
    end
  end

  // Register file flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_q <= SENSE_CTRL_RST;
      gate_cfg_q <= GATE_CFG_RST;
      basic_q <= '0;
    end else begin
      sense_q <= sense_d;
      gate_cfg_q <= gate_cfg_d;
      basic_q <= basic_d;
    end
  end

  // Analog controls: sleep plays no part, so the oscillator keeps running.
  assign sense_powered = sense_q.enable;
  assign osc_run = sense_q.enable && (sense_q.range != RANGE_OFF);
  assign osc_current_range = sense_q.enable ? sense_q.range : RANGE_OFF;
  assign osc_edge_live = osc_rise && osc_run;

  // Gate sources; a late watchdog overflow simply arrives later and stretches the window.
  assign gate_lvl = {wdt_overflow, gate_alt_in};

  // Oscillator synchroniser.
  csf_sync_edge u_osc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(osc_in),
    .level(osc_level),
    .rise(osc_rise)
  );

  // Gate and gated counter; it runs on the core clock, which is kept during sleep.
  csf_gate_counter u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(gate_cfg_q),
    .gate_lvl(gate_lvl),
    .osc_rise(osc_edge_live),
    .load_en(load_en),
    .load_val(load_val),
    .count(gated_count),
    .window_open(window_open)
  );

  // Entering sleep leaves a running oscillator running.
  a_osc_in_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(core_sleep) && osc_run && !do_write) |=> osc_run)
    else $error("oscillator stopped on entering sleep");

  // The basic counter holds in sleep unless software writes it.
  a_basic_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (core_sleep && !do_write) |=> basic_q == $past(basic_q))
    else $error("basic counter moved during sleep");

  // A write response stands unchanged until it is taken.
  a_bresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before being taken");

  // A read answer comes exactly one cycle after the address is taken.
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer not given one cycle after address");

  // Disabling the module drives the range outputs to off.
  a_disable_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && cur_strb[0] && word_of(cur_addr) == OFF_SENSE_CTRL && !cur_data[SC_ENABLE_BIT])
    |=> (!osc_run && osc_current_range == RANGE_OFF))
    else $error("module still running after disable");

endmodule
`default_nettype wire

// [csf_pad_model.sv]
// Sense oscillator and touch pad model for the frequency counter bench.
`timescale 1ns/1ns
`default_nettype none
module csf_pad_model (
  input wire logic run,
  input wire logic touched,
  output logic osc
);
  // Half period in ns; a touched pad adds load and slows the oscillator.
  int half_ns;
  // The oscillator toggles only while running and rests low when stopped.
  initial begin
    osc = 1'b0;
    forever begin
      half_ns = touched ? 37 : 21;
      if (run) begin
        #(half_ns) osc = ~osc;
      end else begin
        osc = 1'b0;
        #5;
      end
    end
  end
endmodule
`default_nettype wire

// [test_cap_sense_freq_counter.sv]
// Self-checking bench for the capacitive sense frequency counter.
`timescale 1ns/1ns
`default_nettype none
module test_cap_sense_freq_counter;
  import csf_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, sleep = 1'b0, wdt = 1'b0, touch = 1'b0;
  logic br = 1'b1;
  logic [3:0] ws = 4'hf;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdata, got, cu, cl, thr;
  logic [1:0] bresp, rresp, rng;
  logic awr, wr_rdy, bv, arr, rv, pow, run, osc;
  logic [65:0] re;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0, n_tests = 0, i;
  // Free-running 125 MHz clock.
  always #4 aclk = ~aclk;
  csf_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .core_sleep(sleep), .osc_in(osc), .wdt_overflow(wdt), .gate_alt_in(3'h0),
    .sense_powered(pow), .osc_run(run), .osc_current_range(rng));
  csf_pad_model pad (.run(run), .touched(touch), .osc(osc));
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ends the run as a failure when a wait runs out.
  task automatic stuck(input int n);
    if (n >= 50) begin
      errors++;
      wrap_up();
    end
  endtask
  // Bus write; the expected response is queued for the monitor.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bq.push_back(er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) break;
    end
    stuck(n);
  endtask
  // Bus read; expected data, compare mask and response are queued.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er,
                    output logic [31:0] d);
    int n;
    rq.push_back({er, m, e});
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdata;
    stuck(n);
  endtask
  // Watchdog overflow pulse of one cycle.
  task automatic pulse();
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
    @(posedge aclk);
  endtask
  // One fixed-length window: clear, open, close, then check the count holds.
  task automatic win(output logic [31:0] c);
    logic [31:0] c2;
    wr(OFF_GATED_COUNT, 32'h0, RESP_OKAY);
    pulse();
    repeat (4) @(posedge aclk);
    rd(OFF_GATE_CTRL, 32'h8, 32'h8, RESP_OKAY, c);
    repeat (300) @(posedge aclk);
    pulse();
    repeat (8) @(posedge aclk);
    rd(OFF_GATE_CTRL, 32'h0, 32'h8, RESP_OKAY, c);
    rd(OFF_GATED_COUNT, 32'h0, 32'h0, RESP_OKAY, c);
    repeat (50) @(posedge aclk);
    rd(OFF_GATED_COUNT, c, 32'hffff, RESP_OKAY, c2);
  endtask
  // Monitor takes the oldest note whenever a response is taken.
  always @(posedge aclk) begin
    if (bv && br) chk("bresp", 32'(bresp), 32'(bq.pop_front()));
    if (rv) begin
      re = rq.pop_front();
      chk("rresp", 32'(rresp), 32'(re[65:64]));
      chk("rdata", rdata & re[63:32], re[31:0] & re[63:32]);
    end
  end
  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge aclk);
    errors++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'hfee1e185));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 20; i += 4) rd(12'(i), 32'h0, 32'hffffffff, RESP_OKAY, got);
    wr(12'h020, 32'hff, RESP_SLVERR);
    rd(12'h020, 32'h0, 32'hffffffff, RESP_SLVERR, got);
    for (i = 0; i < 4; i++) begin
      wr(OFF_SENSE_CTRL, {24'($urandom()), 4'hf, 2'(i), 2'h3}, RESP_OKAY);
      rd(OFF_SENSE_CTRL, 32'h81 | (i << 2), 32'hfd, RESP_OKAY, got);
      chk("range", 32'(rng), i);
      chk("run", 32'(run), 32'(i != 0));
      chk("powered", 32'(pow), 32'h1);
    end
    // The response to this write is left waiting for a few cycles before it is taken.
    br <= 1'b0;
    wr(OFF_SENSE_CTRL, 32'h0e, RESP_OKAY);
    repeat (2) @(posedge aclk);
    br <= 1'b1;
    @(posedge aclk);
    chk("off range", 32'(rng), 32'h0);
    chk("off power", 32'(pow), 32'h0);
    rd(OFF_SENSE_CTRL, 32'h0c, 32'hff, RESP_OKAY, got);
    wr(OFF_COUNTER_CTRL, 32'h1, RESP_OKAY);
    wr(OFF_GATE_CTRL, 32'h80, RESP_OKAY);
    wr(OFF_SENSE_CTRL, 32'h8d, RESP_OKAY);
    // Sleep starts while the oscillator runs and no write is committing.
    sleep <= 1'b1;
    @(posedge aclk);
    wr(OFF_GATED_COUNT, 32'h0, RESP_OKAY);
    wr(OFF_BASIC_COUNT, 32'h0, RESP_OKAY);
    repeat (100) @(posedge aclk);
    rd(OFF_GATED_COUNT, 32'h0, 32'hffff, RESP_OKAY, got);
    rd(OFF_BASIC_COUNT, 32'h0, 32'hff, RESP_OKAY, got);
    wr(OFF_GATE_CTRL, 32'hc3, RESP_OKAY);
    pulse();
    repeat (4) @(posedge aclk);
    wr(OFF_GATE_CTRL, 32'h83, RESP_OKAY);
    rd(OFF_GATE_CTRL, 32'h83, 32'hcb, RESP_OKAY, got);
    wr(OFF_GATE_CTRL, 32'hc3, RESP_OKAY);
    win(cu);
    touch <= 1'b1;
    win(cl);
    chk("unloaded count", 32'(cu != 0), 32'h1);
    chk("loaded lower", 32'(cl < cu), 32'h1);
    thr = (cu + cl) / 2;
    chk("threshold", 32'(thr >= cl && thr <= cu), 32'h1);
    sleep <= 1'b0;
    repeat (100) @(posedge aclk);
    rd(OFF_BASIC_COUNT, 32'h0, 32'h0, RESP_OKAY, got);
    chk("basic awake", 32'(got != 0), 32'h1);
    // Lane 1 alone loads the high byte of the held count; lane 0 off leaves sense control alone.
    ws <= 4'h2;
    wr(OFF_GATED_COUNT, 32'hab00, RESP_OKAY);
    ws <= 4'he;
    wr(OFF_SENSE_CTRL, 32'h0, RESP_OKAY);
    ws <= 4'hf;
    rd(OFF_GATED_COUNT, (cl & 32'hff) | 32'hab00, 32'hffff, RESP_OKAY, got);
    rd(OFF_SENSE_CTRL, 32'h8d, 32'hfd, RESP_OKAY, got);
    // A running oscillator shows both sourcing and sinking in the status bit.
    thr = 32'h0;
    for (i = 0; i < 8; i++) begin
      rd(OFF_SENSE_CTRL, 32'h0, 32'h0, RESP_OKAY, got);
      thr |= 32'h1 << got[SC_STATUS_BIT];
    end
    chk("status toggles", thr, 32'h3);
    wrap_up();
  end
endmodule
`default_nettype wire
